// File: dv/rtc_daylight_saving_adjust_tb_top.sv
// Self-checking testbench of the daylight saving adjust block
`timescale 1ns/100ps
`default_nettype none
module rtc_daylight_saving_adjust_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr_en = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [4:0] cur_month = 5'h00;
   logic [5:0] cur_date = 6'h00;
   logic [2:0] cur_weekday = 3'h0;
   logic [5:0] cur_hour = 6'h00;
   logic [4:0] days_in_month = 5'h1f;
   logic hour_advance;
   logic hour_retard;
   logic forward_change_done_flag;
   logic saving_time_enable_bit;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   int adv_n;
   int ret_n;
   int adv_at;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   // Masked writes first, then the example setup so it stays programmed
   row_t rows [13] = '{'{8'h15, 8'hff, 8'h9f}, '{8'h16, 8'hff, 8'h7f}, '{8'h18, 8'hff, 8'h3f},
      '{8'h19, 8'hff, 8'h1f}, '{8'h20, 8'hff, 8'h00}, '{8'h15, 8'h84, 8'h84},
      '{8'h16, 8'h48, 8'h48}, '{8'h17, 8'h00, 8'h00}, '{8'h18, 8'h02, 8'h02},
      '{8'h19, 8'h10, 8'h10}, '{8'h1a, 8'h78, 8'h78}, '{8'h1b, 8'h00, 8'h00},
      '{8'h1c, 8'h02, 8'h02}};

   rtc_daylight_saving_adjust i_dut (
      .clk(clk),
      .nrst(nrst),
      .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .cur_month(cur_month),
      .cur_date(cur_date),
      .cur_weekday(cur_weekday),
      .cur_hour(cur_hour),
      .days_in_month(days_in_month),
      .hour_advance(hour_advance),
      .hour_retard(hour_retard),
      .forward_change_done_flag(forward_change_done_flag),
      .saving_time_enable_bit(saving_time_enable_bit)
   );

   always #2.5 clk = ~clk;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      #1;
      check(reg_rdata, e, "register readback");
   endtask : rd

   // Hold one calendar value for n cycles, count both shift pulses and time the first advance
   task automatic run_cal(input logic [4:0] mo, input logic [5:0] dt, input logic [2:0] wd,
         input logic [5:0] hr, input logic [4:0] dim, input int n);
      @(posedge clk);
      cur_month <= mo;
      cur_date <= dt;
      cur_weekday <= wd;
      cur_hour <= hr;
      days_in_month <= dim;
      adv_n = 0;
      ret_n = 0;
      adv_at = 0;
      for (int i = 1; i <= n; i++) begin
         @(posedge clk);
         #1;
         if (hour_advance === 1'b1) begin
            adv_n++;
            if (adv_at == 0) adv_at = i;
         end
         if (hour_retard === 1'b1) ret_n++;
      end
   endtask : run_cal

   task automatic flags(input logic f, input logic en);
      check({7'h00, forward_change_done_flag}, {7'h00, f}, "done flag");
      check({7'h00, saving_time_enable_bit}, {7'h00, en}, "enable bit");
   endtask : flags

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         $display("BAD %0t run did not complete", $time);
         tally_and_finish();
      end
   end

   initial begin
      repeat (19) @(posedge clk);
      #1;
      flags(1'b0, 1'b0);
      check({6'h00, hour_advance, hour_retard}, 8'h00, "pulses in reset");
      @(posedge clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      flags(1'b0, 1'b1);
      // Second week Sunday must not match week one
      run_cal(5'h04, 6'h08, 3'h0, 6'h02, 5'h1e, 6);
      check(8'(adv_n), 8'h00, "advance outside week one");
      run_cal(5'h04, 6'h01, 3'h0, 6'h03, 5'h1e, 6);
      check(8'(adv_n), 8'h00, "advance at wrong hour");
      // Match held for many cycles still shifts only once
      run_cal(5'h04, 6'h01, 3'h0, 6'h02, 5'h1e, 10);
      check(8'(adv_n), 8'h01, "forward shift count");
      check(8'(adv_at), 8'h02, "forward shift latency");
      flags(1'b1, 1'b1);
      // Sunday the 18th is not the last one of a 31 day month
      run_cal(5'h10, 6'h18, 3'h0, 6'h02, 5'h1f, 6);
      check(8'(ret_n), 8'h00, "reverse before last week");
      run_cal(5'h10, 6'h25, 3'h0, 6'h02, 5'h1f, 10);
      check(8'(ret_n), 8'h01, "reverse shift count");
      check(8'(adv_n), 8'h00, "no advance at reverse");
      flags(1'b0, 1'b1);
      // Date matching instead of week/day
      wr(8'h16, 8'h00);
      wr(8'h17, 8'h05);
      run_cal(5'h04, 6'h05, 3'h3, 6'h02, 5'h1e, 8);
      check(8'(adv_n), 8'h01, "date mode forward");
      flags(1'b1, 1'b1);
      wr(8'h15, 8'h04);
      repeat (4) @(posedge clk);
      #1;
      flags(1'b0, 1'b0);
      run_cal(5'h10, 6'h25, 3'h0, 6'h02, 5'h1f, 8);
      check(8'(ret_n + adv_n), 8'h00, "shift while disabled");
      // Week two covers the 8th to the 14th; date register left at 05
      wr(8'h16, 8'h50);
      wr(8'h15, 8'h84);
      run_cal(5'h04, 6'h15, 3'h0, 6'h02, 5'h1e, 6);
      check(8'(adv_n), 8'h00, "advance after week two");
      run_cal(5'h04, 6'h14, 3'h0, 6'h02, 5'h1e, 8);
      check(8'(adv_n), 8'h01, "week two forward");
      flags(1'b1, 1'b1);
      // Power-up in mid-run drops the flag and the setup
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      flags(1'b0, 1'b0);
      check({6'h00, hour_advance, hour_retard}, 8'h00, "pulses after power-up");
      @(posedge clk);
      nrst <= 1'b1;
      rd(8'h15, 8'h00);
      tally_and_finish();
   end
endmodule : rtc_daylight_saving_adjust_tb_top
`default_nettype wire

// File: hdl/dst_match.sv
// Calendar comparator for one daylight saving change point
`timescale 1ns/100ps
`default_nettype none
module dst_match (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [dst_pkg::MONTH_W-1:0] month_bcd,
   input wire logic sel_week_day,
   input wire logic [dst_pkg::WEEK_W-1:0] week,
   input wire logic [dst_pkg::DAY_W-1:0] weekday,
   input wire logic [dst_pkg::DATE_W-1:0] date_bcd,
   input wire logic [dst_pkg::HOUR_W-1:0] hour_bcd,
   input wire logic [dst_pkg::MONTH_W-1:0] cur_month,
   input wire logic [dst_pkg::DATE_W-1:0] cur_date,
   input wire logic [dst_pkg::DAY_W-1:0] cur_weekday,
   input wire logic [dst_pkg::HOUR_W-1:0] cur_hour,
   input wire logic [dst_pkg::DAYS_W-1:0] days_in_month,
   output logic hit_q
);
   logic [6:0] date_bin;
   logic [6:0] first_day;
   logic [6:0] last_day;
   logic in_week;
   logic day_ok;
   logic hit_d;

   // BCD date to binary: tens times ten plus ones
   assign date_bin = 7'({cur_date[5:4], 3'b000}) + 7'({cur_date[5:4], 1'b0})
                     + 7'(cur_date[3:0]);
   // Widened first, so week times seven cannot wrap at three bits
   assign first_day = (7'(week) - 7'h01) * dst_pkg::DAYS_PER_WEEK + 7'h01;
   assign last_day = 7'(week) * dst_pkg::DAYS_PER_WEEK;

   always_comb begin
      if (week == dst_pkg::WEEK_LAST) begin
         // Last week holds whether the month has four or five such days
         in_week = (date_bin + dst_pkg::DAYS_PER_WEEK) > 7'(days_in_month);
      end else begin
         in_week = (week != 3'h0) && (date_bin >= first_day) && (date_bin <= last_day);
      end
   end

   // Date register plays no part once week/day is selected
   assign day_ok = sel_week_day ? (in_week && (weekday == cur_weekday))
                                : (date_bcd == cur_date);
   assign hit_d = (month_bcd == cur_month) && (hour_bcd == cur_hour) && day_ok;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= hit_d;
      end
   end

   property p_last_week;
      @(posedge clk) disable iff (!nrst)
      (sel_week_day && week == dst_pkg::WEEK_LAST && month_bcd == cur_month
       && hour_bcd == cur_hour && weekday == cur_weekday
       && (7'(days_in_month) - date_bin) < dst_pkg::DAYS_PER_WEEK) |=> hit_q;
   endproperty
   a_last_week: assert property (p_last_week) else $error("last week day missed");

   property p_date_ignored;
      @(posedge clk) disable iff (!nrst)
      (sel_week_day && weekday != cur_weekday) |=> !hit_q;
   endproperty
   a_date_ignored: assert property (p_date_ignored) else $error("date used in week mode");

   property p_week_one;
      @(posedge clk) disable iff (!nrst)
      (sel_week_day && week == 3'h1 && date_bin > 7'h07) |=> !hit_q;
   endproperty
   a_week_one: assert property (p_week_one) else $error("first week matched late date");
endmodule : dst_match
`default_nettype wire

// File: hdl/dst_pkg.sv
// Register map, field layout and reset values of the daylight saving block
`default_nettype none
package dst_pkg;
   localparam int NUM_REGS = 8;
   localparam logic [7:0] OFS_FWD_MONTH = 8'h15;
   localparam logic [7:0] OFS_FWD_WEEK_DAY = 8'h16;
   localparam logic [7:0] OFS_FWD_DATE = 8'h17;
   localparam logic [7:0] OFS_FWD_HOUR = 8'h18;
   localparam logic [7:0] OFS_REV_MONTH = 8'h19;
   localparam logic [7:0] OFS_REV_WEEK_DAY = 8'h1a;
   localparam logic [7:0] OFS_REV_DATE = 8'h1b;
   localparam logic [7:0] OFS_REV_HOUR = 8'h1c;
   // Index of each register within the block, offset minus the first one
   localparam int IDX_FWD_MONTH = 0;
   localparam int IDX_FWD_WEEK_DAY = 1;
   localparam int IDX_FWD_DATE = 2;
   localparam int IDX_FWD_HOUR = 3;
   localparam int IDX_REV_MONTH = 4;
   localparam int IDX_REV_WEEK_DAY = 5;
   localparam int IDX_REV_DATE = 6;
   localparam int IDX_REV_HOUR = 7;
   // Writable bits per register; the rest read as zero
   localparam logic [7:0] MASK_FWD_MONTH = 8'h9f;
   localparam logic [7:0] MASK_WEEK_DAY = 8'h7f;
   localparam logic [7:0] MASK_DATE = 8'h3f;
   localparam logic [7:0] MASK_HOUR = 8'h3f;
   localparam logic [7:0] MASK_REV_MONTH = 8'h1f;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   // Field positions
   localparam int ENABLE_BIT = 7;
   localparam int SELECT_BIT = 6;
   localparam int WEEK_LSB = 3;
   localparam int WEEK_W = 3;
   localparam int DAY_LSB = 0;
   localparam int DAY_W = 3;
   localparam int MONTH_W = 5;
   localparam int DATE_W = 6;
   localparam int HOUR_W = 6;
   localparam int DAYS_W = 5;
   localparam logic [2:0] WEEK_LAST = 3'h7;
   localparam logic [6:0] DAYS_PER_WEEK = 7'h07;
endpackage : dst_pkg
`default_nettype wire

// File: hdl/rtc_daylight_saving_adjust.sv
// Daylight saving adjust: change point registers, matching and hour shift control
// Function
// - Time moves forward at the forward point and back at the reverse point, every year.
// - The enable bit is bit 7 of the forward month register above the BCD month.
// - Week/day registers hold a week, a weekday and a week/day-instead-of-date select bit.
// - Hour registers hold a plain BCD hour with no military select bit.
// - The reverse month register holds a plain BCD month only.
// - Week code seven means the last matching weekday of the month.
// - The forward done flag goes to one once the forward shift is applied.
// - The flag goes to zero on the reverse shift, on power-up and when enable is cleared.
`timescale 1ns/100ps
`default_nettype none
module rtc_daylight_saving_adjust (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [dst_pkg::MONTH_W-1:0] cur_month,
   input wire logic [dst_pkg::DATE_W-1:0] cur_date,
   input wire logic [dst_pkg::DAY_W-1:0] cur_weekday,
   input wire logic [dst_pkg::HOUR_W-1:0] cur_hour,
   input wire logic [dst_pkg::DAYS_W-1:0] days_in_month,
   output logic hour_advance,
   output logic hour_retard,
   output logic forward_change_done_flag,
   output logic saving_time_enable_bit
);
   typedef enum logic {STANDARD_TIME, SUMMER_TIME} summer_time_shift_t;

   localparam logic [7:0] WR_MASK [dst_pkg::NUM_REGS] = '{
      dst_pkg::MASK_FWD_MONTH, dst_pkg::MASK_WEEK_DAY, dst_pkg::MASK_DATE,
      dst_pkg::MASK_HOUR, dst_pkg::MASK_REV_MONTH, dst_pkg::MASK_WEEK_DAY,
      dst_pkg::MASK_DATE, dst_pkg::MASK_HOUR};

   logic [7:0] regs_q [dst_pkg::NUM_REGS];
   logic [7:0] reg_rdata_d;
   logic [7:0] reg_rdata_q;
   summer_time_shift_t shift_q;
   summer_time_shift_t shift_d;
   logic fwd_hit;
   logic rev_hit;
   logic advance_d;
   logic retard_d;
   logic advance_q;
   logic retard_q;
   logic enable;

   // Register file: one write decode per register, reserved bits dropped
   for (genvar i = 0; i < dst_pkg::NUM_REGS; i++) begin : g_reg
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            regs_q[i] <= dst_pkg::REG_RESET;
         end else if (reg_wr_en && reg_addr == dst_pkg::OFS_FWD_MONTH + 8'(i)) begin
            regs_q[i] <= reg_wdata & WR_MASK[i];
         end
      end
   end

   // Read data is registered; unmapped offsets read zero
   always_comb begin
      reg_rdata_d = dst_pkg::RDATA_UNMAPPED;
      if (reg_addr >= dst_pkg::OFS_FWD_MONTH && reg_addr <= dst_pkg::OFS_REV_HOUR) begin
         reg_rdata_d = regs_q[3'(reg_addr - dst_pkg::OFS_FWD_MONTH)];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_q <= dst_pkg::REG_RESET;
      end else begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign enable = regs_q[dst_pkg::IDX_FWD_MONTH][dst_pkg::ENABLE_BIT];
   assign saving_time_enable_bit = enable;

   dst_match u_fwd_match (
      .clk(clk),
      .nrst(nrst),
      .month_bcd(regs_q[dst_pkg::IDX_FWD_MONTH][dst_pkg::MONTH_W-1:0]),
      .sel_week_day(regs_q[dst_pkg::IDX_FWD_WEEK_DAY][dst_pkg::SELECT_BIT]),
      .week(regs_q[dst_pkg::IDX_FWD_WEEK_DAY][dst_pkg::WEEK_LSB +: dst_pkg::WEEK_W]),
      .weekday(regs_q[dst_pkg::IDX_FWD_WEEK_DAY][dst_pkg::DAY_LSB +: dst_pkg::DAY_W]),
      .date_bcd(regs_q[dst_pkg::IDX_FWD_DATE][dst_pkg::DATE_W-1:0]),
      .hour_bcd(regs_q[dst_pkg::IDX_FWD_HOUR][dst_pkg::HOUR_W-1:0]),
      .cur_month(cur_month),
      .cur_date(cur_date),
      .cur_weekday(cur_weekday),
      .cur_hour(cur_hour),
      .days_in_month(days_in_month),
      .hit_q(fwd_hit)
   );

   dst_match u_rev_match (
      .clk(clk),
      .nrst(nrst),
      .month_bcd(regs_q[dst_pkg::IDX_REV_MONTH][dst_pkg::MONTH_W-1:0]),
      .sel_week_day(regs_q[dst_pkg::IDX_REV_WEEK_DAY][dst_pkg::SELECT_BIT]),
      .week(regs_q[dst_pkg::IDX_REV_WEEK_DAY][dst_pkg::WEEK_LSB +: dst_pkg::WEEK_W]),
      .weekday(regs_q[dst_pkg::IDX_REV_WEEK_DAY][dst_pkg::DAY_LSB +: dst_pkg::DAY_W]),
      .date_bcd(regs_q[dst_pkg::IDX_REV_DATE][dst_pkg::DATE_W-1:0]),
      .hour_bcd(regs_q[dst_pkg::IDX_REV_HOUR][dst_pkg::HOUR_W-1:0]),
      .cur_month(cur_month),
      .cur_date(cur_date),
      .cur_weekday(cur_weekday),
      .cur_hour(cur_hour),
      .days_in_month(days_in_month),
      .hit_q(rev_hit)
   );

   // Season state gates each change point, so a match that lingers,
   // or the reverse hour coming round again after set-back, shifts only once
   always_comb begin
      shift_d = shift_q;
      advance_d = 1'b0;
      retard_d = 1'b0;
      unique case (shift_q)
         STANDARD_TIME: begin
            if (enable && fwd_hit) begin
               shift_d = SUMMER_TIME;
               advance_d = 1'b1;
            end
         end
         SUMMER_TIME: begin
            if (!enable) begin
               shift_d = STANDARD_TIME;
            end else if (rev_hit) begin
               shift_d = STANDARD_TIME;
               retard_d = 1'b1;
            end
         end
      endcase
   end

   // Power-up is the asynchronous reset; the flag starts clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shift_q <= STANDARD_TIME;
      end else begin
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         advance_q <= 1'b0;
         retard_q <= 1'b0;
      end else begin
         advance_q <= advance_d;
         retard_q <= retard_d;
      end
   end

   assign hour_advance = advance_q;
   assign hour_retard = retard_q;
   assign forward_change_done_flag = (shift_q == SUMMER_TIME);

   property p_forward_shift;
      @(posedge clk) disable iff (!nrst)
      (enable && fwd_hit && shift_q == STANDARD_TIME) |=> hour_advance && forward_change_done_flag;
   endproperty
   a_forward_shift: assert property (p_forward_shift) else $error("forward shift missed");

   property p_reverse_shift;
      @(posedge clk) disable iff (!nrst)
      (enable && rev_hit && forward_change_done_flag) |=> hour_retard && !forward_change_done_flag;
   endproperty
   a_reverse_shift: assert property (p_reverse_shift) else $error("reverse shift missed");

   property p_flag_set;
      @(posedge clk) disable iff (!nrst)
      $rose(forward_change_done_flag) |-> hour_advance;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag rose without advance");

   property p_flag_clear;
      @(posedge clk) disable iff (!nrst)
      $fell(forward_change_done_flag) |-> hour_retard || !$past(enable);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag fell without cause");

   property p_disable_clears;
      @(posedge clk) disable iff (!nrst)
      !enable |=> !forward_change_done_flag && !hour_advance;
   endproperty
   a_disable_clears: assert property (p_disable_clears) else $error("flag kept while disabled");

   property p_once_per_event;
      @(posedge clk) disable iff (!nrst)
      hour_advance |=> !hour_advance [*2];
   endproperty
   a_once_per_event: assert property (p_once_per_event) else $error("forward shift repeated");

   property p_no_both;
      @(posedge clk) disable iff (!nrst)
      !(hour_advance && hour_retard);
   endproperty
   a_no_both: assert property (p_no_both) else $error("advance and retard together");

   property p_enable_write;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr == dst_pkg::OFS_FWD_MONTH)
         |=> saving_time_enable_bit == $past(reg_wdata[dst_pkg::ENABLE_BIT])
             && regs_q[dst_pkg::IDX_FWD_MONTH][6:5] == 2'h0;
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable bit not stored");

   property p_hour_plain;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr == dst_pkg::OFS_FWD_HOUR)
         |=> regs_q[dst_pkg::IDX_FWD_HOUR] == {2'h0, $past(reg_wdata[5:0])};
   endproperty
   a_hour_plain: assert property (p_hour_plain) else $error("hour register not plain BCD");

   property p_rev_month_plain;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr == dst_pkg::OFS_REV_MONTH)
         |=> ##1 regs_q[dst_pkg::IDX_REV_MONTH][7:5] == 3'h0;
   endproperty
   a_rev_month_plain: assert property (p_rev_month_plain) else $error("reverse month extra bits");

   property p_readback;
      @(posedge clk) disable iff (!nrst)
      (!reg_wr_en && reg_addr == dst_pkg::OFS_FWD_WEEK_DAY)
         |=> reg_rdata == $past(regs_q[dst_pkg::IDX_FWD_WEEK_DAY]);
   endproperty
   a_readback: assert property (p_readback) else $error("week/day readback wrong");

   // Register contents: each change point byte keeps only its own fields
   property p_week_day_store;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr == dst_pkg::OFS_FWD_WEEK_DAY)
         |=> regs_q[dst_pkg::IDX_FWD_WEEK_DAY] == {1'b0, $past(reg_wdata[6:0])};
   endproperty
   a_week_day_store: assert property (p_week_day_store) else $error("week/day not stored");

   property p_last_code_store;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr == dst_pkg::OFS_REV_WEEK_DAY)
         |=> regs_q[dst_pkg::IDX_REV_WEEK_DAY] == {1'b0, $past(reg_wdata[6:0])};
   endproperty
   a_last_code_store: assert property (p_last_code_store) else $error("last week code lost");

   property p_rev_hour_plain;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr == dst_pkg::OFS_REV_HOUR)
         |=> regs_q[dst_pkg::IDX_REV_HOUR] == {2'h0, $past(reg_wdata[5:0])};
   endproperty
   a_rev_hour_plain: assert property (p_rev_hour_plain) else $error("reverse hour not plain");

   property p_rev_month_store;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr == dst_pkg::OFS_REV_MONTH)
         |=> regs_q[dst_pkg::IDX_REV_MONTH] == {3'h0, $past(reg_wdata[4:0])};
   endproperty
   a_rev_month_store: assert property (p_rev_month_store) else $error("reverse month lost");

   property p_unmapped_write;
      @(posedge clk) disable iff (!nrst)
      (reg_wr_en && reg_addr > dst_pkg::OFS_REV_HOUR)
         |=> $stable(saving_time_enable_bit);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("stray write hit enable");

   property p_advance_cause;
      @(posedge clk) disable iff (!nrst)
      hour_advance |-> $past(enable) && $past(fwd_hit) && !$past(forward_change_done_flag);
   endproperty
   a_advance_cause: assert property (p_advance_cause) else $error("advance without match");

   property p_retard_cause;
      @(posedge clk) disable iff (!nrst)
      hour_retard |-> $past(enable) && $past(rev_hit) && $past(forward_change_done_flag);
   endproperty
   a_retard_cause: assert property (p_retard_cause) else $error("retard without match");

   property p_flag_holds;
      @(posedge clk) disable iff (!nrst)
      (forward_change_done_flag && enable && !rev_hit) |=> forward_change_done_flag;
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("done flag dropped early");

   property p_standard_holds;
      @(posedge clk) disable iff (!nrst)
      (!forward_change_done_flag && !(enable && fwd_hit)) |=> !forward_change_done_flag;
   endproperty
   a_standard_holds: assert property (p_standard_holds) else $error("done flag set early");

   property p_no_retard_disabled;
      @(posedge clk) disable iff (!nrst)
      !enable |=> !hour_retard;
   endproperty
   a_no_retard_disabled: assert property (p_no_retard_disabled) else $error("retard while off");

   property p_retard_once;
      @(posedge clk) disable iff (!nrst)
      hour_retard |=> !hour_retard;
   endproperty
   a_retard_once: assert property (p_retard_once) else $error("reverse shift repeated");
endmodule : rtc_daylight_saving_adjust
`default_nettype wire
